// ### verilog/adcrc_regs.sv
// result and computation registers of the converter, AHB-Lite slave
// assumes: convStart/convDone come from converter logic on ref_clk
// Overview of operation
// - left justified, result low holds conversion bits 1:0 in bits 7:6.
// - left justified, result high holds conversion bits 9:2.
// - right justified, result high holds bits 9:8 in 1:0, 7:2 reserved.
// - right justified, result low holds conversion bits 7:0.
// - prior source 1 loads the filter output at each conversion start.
// - prior source 0 loads the conversion result at each conversion start.
// - with prior source 0 the previous pair follows the result layout.
// - the accumulator is 16-bit signed, split into high and low bytes.
// - the filter output is the accumulator shifted right by shift count.
// - a 16-bit writable setpoint may enter the error calculation.
// - a 16-bit error is computed as chosen by the error calc select.
`timescale 1ns/1ns
`include "adcrc_defines.svh"
module adcrc_regs (
    input  wire logic                 ref_clk,    // system clock, 100 MHz
    input  wire logic                 rst_n,      // async reset, active low
    input  wire logic                 hsel,       // slave select
    input  wire logic [7:0]           haddr,      // byte address
    input  wire logic [1:0]           htrans,     // transfer type
    input  wire logic                 hwrite,     // 1: write
    input  wire logic [2:0]           hsize,      // transfer size
    input  wire logic [31:0]          hwdata,     // write data
    input  wire logic                 hready,     // bus ready
    output      logic [31:0]          hrdata,     // read data
    output      logic                 hreadyout,  // slave ready
    output      logic                 hresp,      // always OKAY
    input  wire logic                 convStart,  // conversion begins, pulse
    input  wire logic                 convDone,   // result valid, pulse
    input  wire adcrc_pkg::adcrc_res_t convData,  // new conversion result
    output      adcrc_pkg::adcrc_word_t filterOut, // filter output
    output      adcrc_pkg::adcrc_word_t errOut     // calc error value
);
    import adcrc_pkg::*;

    adcrc_bus_t  busFF,  nxt_bus;
    logic [7:0]  addrFF, nxt_addr;
    logic [31:0] rdataFF, nxt_rdata;
    adcrc_res_t  resFF,  nxt_res;
    adcrc_word_t prevFF, nxt_prev;
    adcrc_word_t accFF,  nxt_acc;
    adcrc_word_t stptFF, nxt_stpt;
    adcrc_word_t errFF,  nxt_err;
    adcrc_word_t filtFF, nxt_filt;
    adcrc_byte_t ctrlFF, nxt_ctrl;
    adcrc_word_t resWord;
    adcrc_word_t calcVal;
    adcrc_word_t resExt;
    logic        rightJust;
    logic        psis;
    logic [2:0]  shiftCnt;
    logic [2:0]  calcSel;
    logic        takeAddr;
    logic [7:0]  wb;

    assign rightJust = ctrlFF[`ADCRC_CTRL_JUSTIFY];
    assign psis      = ctrlFF[`ADCRC_CTRL_PSIS];
    assign shiftCnt  = ctrlFF[`ADCRC_CTRL_SHIFT_HI:`ADCRC_CTRL_SHIFT_LO];
    assign calcSel   = ctrlFF[`ADCRC_CTRL_CALC_HI:`ADCRC_CTRL_CALC_LO];
    assign resExt    = {6'h00, resFF};
    assign wb        = hwdata[7:0];

    adcrc_justify u_justify (
        .rightJustify (rightJust),
        .resIn        (resFF),
        .wordOut      (resWord)
    );

    // filter output leaves from a flip-flop, one cycle behind the accumulator
    assign filterOut = filtFF;
    assign errOut    = errFF;

    // read mux shared by the bus logic
    function automatic logic [7:0] read_byte(input logic [7:0] a,
                                             input adcrc_word_t rw,
                                             input adcrc_word_t pv,
                                             input adcrc_word_t ac,
                                             input adcrc_word_t sp,
                                             input adcrc_word_t er,
                                             input adcrc_byte_t ct);
        case (a)
            `ADCRC_OFS_RES_HIGH:  read_byte = rw[15:8];
            `ADCRC_OFS_RES_LOW:   read_byte = rw[7:0];
            `ADCRC_OFS_PREV_HIGH: read_byte = pv[15:8];
            `ADCRC_OFS_PREV_LOW:  read_byte = pv[7:0];
            `ADCRC_OFS_ACC_HIGH:  read_byte = ac[15:8];
            `ADCRC_OFS_ACC_LOW:   read_byte = ac[7:0];
            `ADCRC_OFS_STPT_HIGH: read_byte = sp[15:8];
            `ADCRC_OFS_STPT_LOW:  read_byte = sp[7:0];
            `ADCRC_OFS_ERR_HIGH:  read_byte = er[15:8];
            `ADCRC_OFS_ERR_LOW:   read_byte = er[7:0];
            `ADCRC_OFS_CTRL:      read_byte = ct;
            default:              read_byte = 8'h00;
        endcase
    endfunction : read_byte

    // bus phase tracking; reads take one wait state so data is fresh
    assign takeAddr  = hsel && htrans[1] && hready;
    assign hreadyout = (busFF != BUS_READ);
    assign hresp     = 1'b0;
    assign hrdata    = rdataFF;

    always_comb begin
        nxt_bus   = busFF;
        nxt_addr  = addrFF;
        nxt_rdata = rdataFF;
        case (busFF)
            BUS_READ: begin
                nxt_rdata = {24'h000000, read_byte(addrFF, resWord, prevFF,
                             accFF, stptFF, errFF, ctrlFF)};
                nxt_bus   = BUS_IDLE;
            end
            default: begin
                if (takeAddr) begin
                    nxt_addr = haddr;
                    nxt_bus  = hwrite ? BUS_WRITE : BUS_READ;
                end else begin
                    nxt_bus  = BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busFF   <= BUS_IDLE;
            addrFF  <= 8'h00;
            rdataFF <= 32'h00000000;
        end else begin
            busFF   <= nxt_bus;
            addrFF  <= nxt_addr;
            rdataFF <= nxt_rdata;
        end
    end

    // register file next values; hardware events win over software writes
    always_comb begin
        logic wr;
        wr       = (busFF == BUS_WRITE);
        nxt_res  = resFF;
        nxt_prev = prevFF;
        nxt_acc  = accFF;
        nxt_stpt = stptFF;
        nxt_ctrl = ctrlFF;
        if (wr) begin
            case (addrFF)
                `ADCRC_OFS_RES_HIGH: begin
                    if (rightJust) begin
                        nxt_res[9:8] = wb[1:0];
                    end else begin
                        nxt_res[9:2] = wb;
                    end
                end
                `ADCRC_OFS_RES_LOW: begin
                    if (rightJust) begin
                        nxt_res[7:0] = wb;
                    end else begin
                        nxt_res[1:0] = wb[7:6];
                    end
                end
                `ADCRC_OFS_ACC_HIGH:  nxt_acc[15:8]  = wb;
                `ADCRC_OFS_ACC_LOW:   nxt_acc[7:0]   = wb;
                `ADCRC_OFS_STPT_HIGH: nxt_stpt[15:8] = wb;
                `ADCRC_OFS_STPT_LOW:  nxt_stpt[7:0]  = wb;
                `ADCRC_OFS_CTRL:      nxt_ctrl = wb & `ADCRC_CTRL_MASK;
                default: ;
            endcase
        end
        if (convStart) begin
            nxt_prev = psis ? filterOut : resWord;
        end
        if (convDone) begin
            nxt_res = convData;
            nxt_acc = adcrc_word_t'(accFF + {6'h00, convData});
        end
    end

    // error calculation, signed 16-bit differences
    always_comb begin
        // signed arithmetic shift of the accumulator
        nxt_filt = adcrc_word_t'($signed(accFF) >>> shiftCnt);
        case (calcSel)
            `ADCRC_CALC_RES_PREV: calcVal = adcrc_word_t'(resExt - prevFF);
            `ADCRC_CALC_STPT_RES: calcVal = adcrc_word_t'(stptFF - resExt);
            `ADCRC_CALC_STPT_FLT: calcVal = adcrc_word_t'(stptFF - filterOut);
            `ADCRC_CALC_FLT_PREV: calcVal = adcrc_word_t'(filterOut - prevFF);
            default:              calcVal = adcrc_word_t'(filterOut - stptFF);
        endcase
        nxt_err = calcVal;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            resFF  <= `ADCRC_RST_RES;
            prevFF <= `ADCRC_RST_WORD;
            accFF  <= `ADCRC_RST_WORD;
            stptFF <= `ADCRC_RST_WORD;
            errFF  <= `ADCRC_RST_WORD;
            filtFF <= `ADCRC_RST_WORD;
            ctrlFF <= `ADCRC_RST_BYTE;
        end else begin
            resFF  <= nxt_res;
            prevFF <= nxt_prev;
            accFF  <= nxt_acc;
            stptFF <= nxt_stpt;
            errFF  <= nxt_err;
            filtFF <= nxt_filt;
            ctrlFF <= nxt_ctrl;
        end
    end

    // checks
    sequence s_read_addr;
        takeAddr && !hwrite;
    endsequence

    sequence s_read_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    chk_left_low_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rightJust |-> (resWord[7:6] == resFF[1:0] && resWord[5:0] == 6'h00))
        else $error("left low byte layout wrong");
    chk_left_high_byte: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        !rightJust |-> resWord[15:8] == resFF[9:2])
        else $error("left high byte layout wrong");
    chk_right_high_bits: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        rightJust |-> resWord[15:8] == {6'h00, resFF[9:8]})
        else $error("right high byte layout wrong");
    chk_right_low_byte: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        convDone && !(busFF == BUS_WRITE) ##1 rightJust
        |-> resWord[7:0] == $past(convData[7:0]))
        else $error("right low byte not the result");
    chk_prev_filter: assert property (@(posedge ref_clk) disable iff (!rst_n)
        convStart && psis |=> prevFF == $past(filterOut))
        else $error("previous value missed filter output");
    chk_prev_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
        convStart && !psis |=> prevFF == $past(resWord))
        else $error("previous value missed result");
    chk_acc_add: assert property (@(posedge ref_clk) disable iff (!rst_n)
        convDone |=> accFF == adcrc_word_t'($past(accFF)
                                + {6'h00, $past(convData)}))
        else $error("accumulator did not add result");
    chk_filter_shift: assert property (@(posedge ref_clk) disable iff (!rst_n)
        shiftCnt == 3'h0 |=> filterOut == $past(accFF))
        else $error("filter differs from unshifted accumulator");
    chk_filter_sign: assert property (@(posedge ref_clk) disable iff (!rst_n)
        shiftCnt == 3'h7 && accFF[15] |=> filterOut[15:8] == 8'hFF)
        else $error("filter output lost the sign");
    chk_acc_high_write: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        busFF == BUS_WRITE && addrFF == `ADCRC_OFS_ACC_HIGH && !convDone
        |=> accFF[15:8] == $past(wb))
        else $error("accumulator high byte not written");
    chk_stpt_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busFF == BUS_WRITE && addrFF == `ADCRC_OFS_STPT_LOW
        |=> stptFF[7:0] == $past(wb))
        else $error("setpoint low byte not written");
    chk_err_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
        calcSel == `ADCRC_CALC_STPT_RES
        ##1 $stable(calcSel) && $stable(stptFF) && $stable(resFF)
        |-> errFF == adcrc_word_t'(stptFF - resExt))
        else $error("error value not setpoint minus result");
    chk_reserved_zero: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        s_read_addr ##0 (haddr == `ADCRC_OFS_RES_HIGH) && rightJust
        ##1 s_read_wait ##0 rightJust |-> hrdata[7:2] == 6'h00)
        else $error("reserved result bits not zero");
endmodule : adcrc_regs

// ### verilog/adcrc_defines.svh
// offsets, field positions, reset values and encodings of the result and
// computation registers; included by the register module and the testbench
`ifndef ADCRC_DEFINES_SVH
`define ADCRC_DEFINES_SVH

// byte addresses, one aligned 32-bit word per register
`define ADCRC_OFS_RES_HIGH   8'h00
`define ADCRC_OFS_RES_LOW    8'h04
`define ADCRC_OFS_PREV_HIGH  8'h08
`define ADCRC_OFS_PREV_LOW   8'h0C
`define ADCRC_OFS_ACC_HIGH   8'h10
`define ADCRC_OFS_ACC_LOW    8'h14
`define ADCRC_OFS_STPT_HIGH  8'h18
`define ADCRC_OFS_STPT_LOW   8'h1C
`define ADCRC_OFS_ERR_HIGH   8'h20
`define ADCRC_OFS_ERR_LOW    8'h24
`define ADCRC_OFS_CTRL       8'h28

// control register fields
`define ADCRC_CTRL_JUSTIFY   0
`define ADCRC_CTRL_PSIS      1
`define ADCRC_CTRL_SHIFT_LO  2
`define ADCRC_CTRL_SHIFT_HI  4
`define ADCRC_CTRL_CALC_LO   5
`define ADCRC_CTRL_CALC_HI   7
`define ADCRC_CTRL_MASK      8'hFF

// error calculation select codes
`define ADCRC_CALC_RES_PREV  3'h0
`define ADCRC_CALC_STPT_RES  3'h1
`define ADCRC_CALC_STPT_FLT  3'h2
`define ADCRC_CALC_FLT_PREV  3'h3

// reset values
`define ADCRC_RST_BYTE       8'h00
`define ADCRC_RST_WORD       16'h0000
`define ADCRC_RST_RES        10'h000

`endif

// ### verilog/adcrc_pkg.sv
// types shared by the result and computation register block
package adcrc_pkg;
    typedef logic [9:0]  adcrc_res_t;
    typedef logic [15:0] adcrc_word_t;
    typedef logic [7:0]  adcrc_byte_t;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } adcrc_bus_t;
endpackage : adcrc_pkg

// ### verilog/adcrc_justify.sv
// places a ten-bit conversion result into a high/low byte pair
// assumes: pure combinational, justify select from the control register
`timescale 1ns/1ns
module adcrc_justify (
    input  wire logic              rightJustify, // 1: right, 0: left
    input  wire adcrc_pkg::adcrc_res_t  resIn,   // conversion result
    output      adcrc_pkg::adcrc_word_t wordOut  // {high byte, low byte}
);
    import adcrc_pkg::*;

    always_comb begin
        if (rightJustify) begin
            wordOut = {6'h00, resIn};
        end else begin
            wordOut = {resIn, 6'h00};
        end
    end
endmodule : adcrc_justify

// ### tb/tb.sv
// self-checking bench for the converter result and computation registers
// assumes: one AHB-Lite slave, bench drives the converter strobes itself
`timescale 1ns/1ns
`include "adcrc_defines.svh"
module tb;
    import adcrc_pkg::*;
    logic                ref_clk;
    logic                rst_n;
    logic                hsel;
    logic                hwrite;
    logic                hreadyout;
    logic                hresp;
    logic                convStart;
    logic                convDone;
    logic [7:0]          haddr;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    adcrc_res_t          convData;
    adcrc_word_t         filterOut;
    adcrc_word_t         errOut;
    int                  failures;
    int                  n_checks;

    adcrc_regs u_adcrc_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .convStart(convStart), .convDone(convDone),
        .convData(convData), .filterOut(filterOut), .errOut(errOut)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk16

    // ready is steady from mid-cycle to the next rising edge
    task automatic waitRdy;
        int n;
        n = 0;
        @(negedge ref_clk);
        while (hreadyout !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 20) begin
            failures++;
            $display("BAD hreadyout exp 1 got timeout");
            stop_test();
        end
    endtask : waitRdy

    // entered and left just after a rising edge
    task automatic xfer(logic wr, logic [7:0] a, logic [7:0] d,
                        output logic [7:0] q);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        waitRdy();
        @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        waitRdy();
        q = hrdata[7:0];
        chk8("hresp", 8'h00, {7'h00, hresp});
        chk8("hrdataHigh", 8'h00, {7'h00, |hrdata[31:8]});
        @(posedge ref_clk);
    endtask : xfer

    task automatic wr8(logic [7:0] a, logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr8

    task automatic rdChk(string nm, logic [7:0] a, logic [7:0] e);
        logic [7:0] q;
        xfer(1'b0, a, 8'h00, q);
        chk8(nm, e, q);
    endtask : rdChk

    task automatic pulse(logic s, logic d, adcrc_res_t v);
        convStart <= s;
        convDone  <= d;
        convData  <= v;
        @(posedge ref_clk);
        convStart <= 1'b0;
        convDone  <= 1'b0;
    endtask : pulse

    task automatic t_reset;
        rdChk("resHigh", `ADCRC_OFS_RES_HIGH, 8'h00);
        wr8(8'h2C, 8'hA5);
        rdChk("unmapped", 8'h2C, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_justify;
        adcrc_res_t  d;
        logic [15:0] w;
        d = 10'h2B7;
        for (int j = 0; j < 2; j++) begin
            wr8(`ADCRC_OFS_CTRL, 8'(j));
            pulse(1'b0, 1'b1, d);
            w = (j == 1) ? {6'h00, d} : {d, 6'h00};
            rdChk("resHigh", `ADCRC_OFS_RES_HIGH, w[15:8]);
            rdChk("resLow", `ADCRC_OFS_RES_LOW, w[7:0]);
            pulse(1'b1, 1'b0, 10'h000);
            rdChk("prevHigh", `ADCRC_OFS_PREV_HIGH, w[15:8]);
            rdChk("prevLow", `ADCRC_OFS_PREV_LOW, w[7:0]);
        end
        wr8(`ADCRC_OFS_RES_HIGH, 8'hFF);
        rdChk("resvHigh", `ADCRC_OFS_RES_HIGH, 8'h03);
        wr8(`ADCRC_OFS_PREV_LOW, 8'h5A);
        rdChk("prevRo", `ADCRC_OFS_PREV_LOW, w[7:0]);
        $display("test justify done");
    endtask : t_justify

    task automatic t_filter;
        logic signed [15:0] a;
        logic [15:0]        e;
        logic [2:0]         sh;
        a = 16'sh8040;
        wr8(`ADCRC_OFS_ACC_HIGH, 8'h80);
        wr8(`ADCRC_OFS_ACC_LOW, 8'h40);
        rdChk("accHigh", `ADCRC_OFS_ACC_HIGH, 8'h80);
        rdChk("accLow", `ADCRC_OFS_ACC_LOW, 8'h40);
        for (int i = 0; i < 2; i++) begin
            sh = (i == 1) ? 3'h7 : 3'h3;
            wr8(`ADCRC_OFS_CTRL, {3'h0, sh, 2'b10});
            e = a >>> sh;
            repeat (2) @(negedge ref_clk);
            chk16("filterOut", e, filterOut);
            @(posedge ref_clk);
            pulse(1'b1, 1'b0, 10'h000);
            rdChk("prevHigh", `ADCRC_OFS_PREV_HIGH, e[15:8]);
            rdChk("prevLow", `ADCRC_OFS_PREV_LOW, e[7:0]);
        end
        $display("test filter done");
    endtask : t_filter

    task automatic errChk(logic [7:0] c, logic [15:0] e);
        wr8(`ADCRC_OFS_CTRL, c);
        repeat (2) @(negedge ref_clk);
        chk16("errOut", e, errOut);
        @(posedge ref_clk);
    endtask : errChk

    task automatic t_error;
        wr8(`ADCRC_OFS_STPT_HIGH, 8'h01);
        wr8(`ADCRC_OFS_STPT_LOW, 8'h23);
        rdChk("stptHigh", `ADCRC_OFS_STPT_HIGH, 8'h01);
        rdChk("stptLow", `ADCRC_OFS_STPT_LOW, 8'h23);
        pulse(1'b0, 1'b1, 10'h045);
        wr8(`ADCRC_OFS_CTRL, 8'h20);
        rdChk("errHigh", `ADCRC_OFS_ERR_HIGH, 8'h00);
        rdChk("errLow", `ADCRC_OFS_ERR_LOW, 8'hDE);
        wr8(`ADCRC_OFS_ACC_HIGH, 8'h00);
        wr8(`ADCRC_OFS_ACC_LOW, 8'h20);
        wr8(`ADCRC_OFS_CTRL, 8'h40);
        wr8(`ADCRC_OFS_ERR_LOW, 8'hFF);
        rdChk("errHigh", `ADCRC_OFS_ERR_HIGH, 8'h01);
        rdChk("errLow", `ADCRC_OFS_ERR_LOW, 8'h03);
        @(negedge ref_clk);
        chk16("errOut", 16'h0103, errOut);
        @(posedge ref_clk);
        errChk(8'h00, 16'h0145);
        errChk(8'h60, 16'h0120);
        errChk(8'h80, 16'hFEFD);
        $display("test error done");
    endtask : t_error

    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        convStart = 1'b0;
        convDone = 1'b0;
        convData = 10'h000;
        failures = 0;
        n_checks = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_justify();
        t_filter();
        t_error();
        stop_test();
    end
endmodule : tb
